// ### verilog/timer_pkg.sv
// constants and types for the capture reload timer
`default_nettype none
package timer_pkg;
	// ==========================================
	// register addresses
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hC8;
	localparam logic [7:0] ADDR_RELOAD_CAPTURE_LOW = 8'hCA;
	localparam logic [7:0] ADDR_RELOAD_CAPTURE_HIGH = 8'hCB;
	localparam logic [7:0] ADDR_COUNT_LOW_BYTE = 8'hCC;
	localparam logic [7:0] ADDR_COUNT_HIGH_BYTE = 8'hCD;
	// ==========================================
	// control field positions
	localparam int BIT_OVERFLOW_FLAG = 7;
	localparam int BIT_EXTERNAL_EVENT_FLAG = 6;
	localparam int BIT_RECEIVE_CLOCK_SELECT = 5;
	localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
	localparam int BIT_EXTERNAL_TRIGGER_ENABLE = 3;
	localparam int BIT_RUN_CONTROL = 2;
	localparam int BIT_TIMER_COUNTER_SELECT = 1;
	localparam int BIT_CAPTURE_SELECT = 0;
	// ==========================================
	// reset values
	localparam logic [7:0] RESET_TIMER_CONTROL = 8'h00;
	localparam logic [15:0] RESET_COUNT = 16'h0000;
	localparam logic [15:0] RESET_RELOAD_CAPTURE = 16'h0000;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
	// ==========================================
	// operating modes
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_AUTORELOAD,
		MODE_CAPTURE,
		MODE_BAUD
	} timer_mode_t;
endpackage
`default_nettype wire

// ### verilog/pin_fall_detect.sv
// synchroniser and falling edge detector for one pin
`default_nettype none
`timescale 1ns/1ns
module pin_fall_detect (
	input wire logic clock,
	input wire logic rst,
	input wire logic pin,
	output logic fall
);
	logic meta_q, sync2_q, sync3_q, level_q;
	logic level_d;
	// ==========================================
	// three stage sampling
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= 1'b1;
			sync2_q <= 1'b1;
			sync3_q <= 1'b1;
			level_q <= 1'b1;
		end else begin
			meta_q <= pin;
			sync2_q <= meta_q;
			sync3_q <= sync2_q;
			level_q <= level_d;
		end
	end
	// ==========================================
	// accepted level and edge
	always_comb begin
		level_d = (sync2_q == sync3_q) ? sync2_q : level_q;
	end
	assign fall = (sync2_q == sync3_q) && !sync2_q && level_q;
endmodule // pin_fall_detect
`default_nettype wire

// ### verilog/capture_reload_timer.sv
// 16-bit timer with autoreload, capture and baud modes
//
// Operation
// - mode from run, clock selects, capture select: off, autoreload, capture, baud.
// - autoreload: rollover sets overflow flag and loads count from reload pair.
// - autoreload with trigger enable: trigger fall reloads count, sets event flag.
// - capture mode: free 16-bit count, overflow sets flag bit 7, interrupts.
// - capture with trigger enable: trigger fall copies count into reload pair.
// - qualifying trigger fall sets event flag bit 6, which can interrupt.
// - baud mode: overflows never set the overflow flag.
// - baud mode: trigger falls still set event flag and may interrupt.
// - count bytes and reload/capture bytes readable, writable by software.
// - count runs while run bit set, holds while clear.
// - counts core clocks, or count pin falls when counter select set.
// - baud mode: overflow pulses go to serial port as receive or transmit bit clock.
`default_nettype none
`timescale 1ns/1ns
module capture_reload_timer
	import timer_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic trigger_input,
	input wire logic count_input,
	output logic timer_irq,
	output logic rx_bit_clock,
	output logic tx_bit_clock,
	output var timer_pkg::timer_mode_t mode
);
	import timer_pkg::*;

	logic [7:0] control_q, control_d;
	logic [15:0] count_q, count_d;
	logic [15:0] reload_q, reload_d;
	logic [7:0] rdata_q, rdata_d;
	logic rx_tick_q, rx_tick_d, tx_tick_q, tx_tick_d;
	logic trig_fall, count_fall;
	logic run, ext_en, tick, overflow, trig_event;
	timer_mode_t mode_c;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic strobe);
		hit = strobe && (a == target);
	endfunction

	// ==========================================
	// pin edge detectors
	pin_fall_detect u_trigger (
		.clock(clock),
		.rst(rst),
		.pin(trigger_input),
		.fall(trig_fall)
	);
	pin_fall_detect u_count (
		.clock(clock),
		.rst(rst),
		.pin(count_input),
		.fall(count_fall)
	);

	// ==========================================
	// mode decode and events
	always_comb begin
		run = control_q[BIT_RUN_CONTROL];
		ext_en = control_q[BIT_EXTERNAL_TRIGGER_ENABLE];
		if (!run) begin
			mode_c = MODE_OFF;
		end else if (control_q[BIT_RECEIVE_CLOCK_SELECT] || control_q[BIT_TRANSMIT_CLOCK_SELECT]) begin
			mode_c = MODE_BAUD;
		end else if (control_q[BIT_CAPTURE_SELECT]) begin
			mode_c = MODE_CAPTURE;
		end else begin
			mode_c = MODE_AUTORELOAD;
		end
		tick = run && (control_q[BIT_TIMER_COUNTER_SELECT] ? count_fall : 1'b1);
		overflow = tick && (count_q == COUNT_ALL_ONES);
		trig_event = ext_en && trig_fall;
	end
	assign mode = mode_c;

	// ==========================================
	// control, count and reload state
	always_comb begin
		control_d = control_q;
		count_d = count_q;
		reload_d = reload_q;
		rx_tick_d = 1'b0;
		tx_tick_d = 1'b0;
		if (hit(sfr_addr, ADDR_TIMER_CONTROL, sfr_wr)) begin
			control_d = sfr_wdata;
		end
		if (hit(sfr_addr, ADDR_RELOAD_CAPTURE_LOW, sfr_wr)) begin
			reload_d[7:0] = sfr_wdata;
		end
		if (hit(sfr_addr, ADDR_RELOAD_CAPTURE_HIGH, sfr_wr)) begin
			reload_d[15:8] = sfr_wdata;
		end
		if (tick) begin
			count_d = count_q + 16'h0001;
		end
		case (mode_c)
			MODE_AUTORELOAD: begin
				if (overflow || trig_event) begin
					count_d = reload_q;
				end
				if (overflow) begin
					control_d[BIT_OVERFLOW_FLAG] = 1'b1;
				end
			end
			MODE_CAPTURE: begin
				if (trig_event) begin
					reload_d = count_q;
				end
				if (overflow) begin
					control_d[BIT_OVERFLOW_FLAG] = 1'b1;
				end
			end
			MODE_BAUD: begin
				if (overflow) begin
					count_d = reload_q;
					rx_tick_d = control_q[BIT_RECEIVE_CLOCK_SELECT];
					tx_tick_d = control_q[BIT_TRANSMIT_CLOCK_SELECT];
				end
			end
			MODE_OFF: begin
			end
			default: begin
			end
		endcase
		if (trig_event) begin
			control_d[BIT_EXTERNAL_EVENT_FLAG] = 1'b1;
		end
		if (hit(sfr_addr, ADDR_COUNT_LOW_BYTE, sfr_wr)) begin
			count_d[7:0] = sfr_wdata;
		end
		if (hit(sfr_addr, ADDR_COUNT_HIGH_BYTE, sfr_wr)) begin
			count_d[15:8] = sfr_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			control_q <= RESET_TIMER_CONTROL;
			count_q <= RESET_COUNT;
			reload_q <= RESET_RELOAD_CAPTURE;
			rx_tick_q <= 1'b0;
			tx_tick_q <= 1'b0;
		end else begin
			control_q <= control_d;
			count_q <= count_d;
			reload_q <= reload_d;
			rx_tick_q <= rx_tick_d;
			tx_tick_q <= tx_tick_d;
		end
	end

	// ==========================================
	// register read port
	always_comb begin
		rdata_d = rdata_q;
		if (sfr_rd) begin
			case (sfr_addr)
				ADDR_TIMER_CONTROL: rdata_d = control_q;
				ADDR_RELOAD_CAPTURE_LOW: rdata_d = reload_q[7:0];
				ADDR_RELOAD_CAPTURE_HIGH: rdata_d = reload_q[15:8];
				ADDR_COUNT_LOW_BYTE: rdata_d = count_q[7:0];
				ADDR_COUNT_HIGH_BYTE: rdata_d = count_q[15:8];
				default: rdata_d = READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= READ_UNMAPPED;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign rx_bit_clock = rx_tick_q;
	assign tx_bit_clock = tx_tick_q;
	assign timer_irq = control_q[BIT_OVERFLOW_FLAG] || control_q[BIT_EXTERNAL_EVENT_FLAG];

	// ==========================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	logic ctl_wr;
	assign ctl_wr = hit(sfr_addr, ADDR_TIMER_CONTROL, sfr_wr);

	property p_mode_off;
		!control_q[BIT_RUN_CONTROL] |-> mode == MODE_OFF;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("mode not off with run clear");

	property p_reload_on_overflow;
		(mode == MODE_AUTORELOAD && overflow && !sfr_wr) |=>
			control_q[BIT_OVERFLOW_FLAG] && count_q == $past(reload_q);
	endproperty
	a_reload_on_overflow: assert property (p_reload_on_overflow) else $error("autoreload missed");

	property p_trigger_reload;
		(mode == MODE_AUTORELOAD && trig_event && !sfr_wr) |=>
			count_q == $past(reload_q) && control_q[BIT_EXTERNAL_EVENT_FLAG];
	endproperty
	a_trigger_reload: assert property (p_trigger_reload) else $error("trigger reload missed");

	property p_capture_wrap;
		(mode == MODE_CAPTURE && overflow && !sfr_wr) |=> count_q == 16'h0000 && control_q[BIT_OVERFLOW_FLAG];
	endproperty
	a_capture_wrap: assert property (p_capture_wrap) else $error("capture overflow wrong");

	property p_capture_copy;
		(mode == MODE_CAPTURE && trig_event && !sfr_wr) |=> reload_q == $past(count_q);
	endproperty
	a_capture_copy: assert property (p_capture_copy) else $error("capture copy wrong");

	property p_baud_no_flag;
		(mode == MODE_BAUD && !control_q[BIT_OVERFLOW_FLAG] && !ctl_wr) |=> !control_q[BIT_OVERFLOW_FLAG];
	endproperty
	a_baud_no_flag: assert property (p_baud_no_flag) else $error("overflow flag set in baud mode");

	property p_baud_event;
		(mode == MODE_BAUD && trig_event) |=> control_q[BIT_EXTERNAL_EVENT_FLAG] ##0 timer_irq;
	endproperty
	a_baud_event: assert property (p_baud_event) else $error("event flag missed in baud mode");

	property p_hold_when_stopped;
		(!control_q[BIT_RUN_CONTROL] && !sfr_wr) |=> $stable(count_q);
	endproperty
	a_hold_when_stopped: assert property (p_hold_when_stopped) else $error("count moved while stopped");

	property p_counter_edge_only;
		(control_q[BIT_TIMER_COUNTER_SELECT] && !count_fall && !trig_event && !sfr_wr && mode != MODE_OFF)
			|=> $stable(count_q);
	endproperty
	a_counter_edge_only: assert property (p_counter_edge_only) else $error("counted without pin edge");

	sequence s_baud_overflow;
		mode == MODE_BAUD && overflow && control_q[BIT_TRANSMIT_CLOCK_SELECT];
	endsequence
	property p_tx_clock;
		s_baud_overflow |=> tx_bit_clock ##1 !tx_bit_clock || $past(overflow);
	endproperty
	a_tx_clock: assert property (p_tx_clock) else $error("transmit bit clock missing");

	property p_flag_sticky;
		(control_q[BIT_EXTERNAL_EVENT_FLAG] && !ctl_wr) |=> control_q[BIT_EXTERNAL_EVENT_FLAG];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("event flag cleared by hardware");
endmodule // capture_reload_timer
`default_nettype wire

// ### tb/pin_model.sv
// partner model driving the trigger and count pins
`default_nettype none
`timescale 1ns/1ns
module pin_model (
	input wire logic clock,
	output logic trigger_input,
	output logic count_input
);
	initial begin
		trigger_input = 1'b1;
		count_input = 1'b1;
	end
	// ==========================================
	// one clean fall, each level held beyond three samples
	task automatic fall(input logic trig);
		@(posedge clock);
		#1;
		if (trig) trigger_input = 1'b0;
		else count_input = 1'b0;
		repeat (5) @(posedge clock);
		#1;
		trigger_input = 1'b1;
		count_input = 1'b1;
		repeat (6) @(posedge clock);
	endtask
endmodule // pin_model
`default_nettype wire

// ### tb/capture_reload_timer_tb.sv
// self-checking bench for the capture reload timer
`default_nettype none
`timescale 1ns/1ns
module capture_reload_timer_tb;
	import timer_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic trigger_input, count_input, timer_irq, rx_bit_clock, tx_bit_clock;
	timer_mode_t mode;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_rx = 0;
	int n_tx = 0;
	logic [7:0] ctl [5] = '{8'h00, 8'h04, 8'h05, 8'h14, 8'h24};
	timer_mode_t mexp [5] = '{MODE_OFF, MODE_AUTORELOAD, MODE_CAPTURE, MODE_BAUD, MODE_BAUD};
	logic [7:0] adr [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
	always #25 clock = ~clock;
	capture_reload_timer uut (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .trigger_input(trigger_input),
		.count_input(count_input), .timer_irq(timer_irq), .rx_bit_clock(rx_bit_clock),
		.tx_bit_clock(tx_bit_clock), .mode(mode));
	pin_model pins (.clock(clock), .trigger_input(trigger_input), .count_input(count_input));
	// ==========================================
	// access tasks and checks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(posedge clock);
		#1;
		sfr_wr = 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		#1;
		sfr_rd = 1'b1;
		sfr_addr = a;
		@(posedge clock);
		#1;
		sfr_rd = 1'b0;
		@(posedge clock);
		#1;
		chk($sformatf("reg %h", a), exp, sfr_rdata);
	endtask
	task automatic give_verdict;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (rx_bit_clock === 1'b1) n_rx++;
		if (tx_bit_clock === 1'b1) n_tx++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict;
		end
	end
	// ==========================================
	// scenarios
	initial begin
		repeat (5) @(posedge clock);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 6; i++) rc(adr[i], 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(8'hC8, ctl[i]);
			chk("mode", {6'h00, mexp[i]}, {6'h00, mode});
		end
		wr(8'hC8, 8'h00);
		wr(8'hCA, 8'h34);
		wr(8'hCB, 8'h12);
		wr(8'hCC, 8'hFE);
		wr(8'hCD, 8'hFF);
		rc(8'hCA, 8'h34);
		rc(8'hCC, 8'hFE);
		wr(8'hC8, 8'h04);
		repeat (10) @(posedge clock);
		rc(8'hC8, 8'h84);
		wr(8'hC8, 8'h80);
		rc(8'hCD, 8'h12);
		repeat (20) @(posedge clock);
		rc(8'hC8, 8'h80);
		chk("irq", 8'h01, {7'h00, timer_irq});
		wr(8'hC8, 8'h0C);
		wr(8'hCD, 8'h50);
		pins.fall(1'b1);
		wr(8'hC8, 8'h48);
		rc(8'hCD, 8'h12);
		rc(8'hC8, 8'h48);
		wr(8'hCA, 8'h55);
		wr(8'hCB, 8'h55);
		wr(8'hCC, 8'hF8);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h0D);
		repeat (20) @(posedge clock);
		rc(8'hC8, 8'h8D);
		pins.fall(1'b1);
		rc(8'hC8, 8'hCD);
		rc(8'hCB, 8'h00);
		wr(8'hC8, 8'h02);
		chk("irq", 8'h00, {7'h00, timer_irq});
		wr(8'hCC, 8'h00);
		wr(8'hCD, 8'h00);
		wr(8'hC8, 8'h06);
		for (int i = 0; i < 3; i++) pins.fall(1'b0);
		wr(8'hC8, 8'h02);
		pins.fall(1'b0);
		rc(8'hCC, 8'h03);
		rc(8'hCC, 8'h03);
		wr(8'hCA, 8'hF0);
		wr(8'hCB, 8'hFF);
		wr(8'hCC, 8'hF0);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h3C);
		repeat (100) @(posedge clock);
		pins.fall(1'b1);
		rc(8'hC8, 8'h7C);
		chk("bit clocks", 8'h01, {7'h00, (n_rx > 3 && n_tx > 3)});
		chk("irq", 8'h01, {7'h00, timer_irq});
		give_verdict;
	end
endmodule // capture_reload_timer_tb
`default_nettype wire
